// [testbench/test_usb_power_suspend_control.sv]
`timescale 1ns/1ps
module test_usb_power_suspend_control;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout, hresp, usb_clk_en, xcvr_low_power, pins_owned, analog_en;
	logic outputs_hold, sleep_block, irq, bus_activity, notify_pending;
	logic [31:0] hrdata;
	logic [31:0] q;
	logic [4:0] outs;
	int failures = 0;
	int samples_checked = 0;
	int n;
	assign outs = {usb_clk_en, xcvr_low_power, pins_owned, analog_en, outputs_hold};
	// 200 MHz clock
	always #2.5 hclk = ~hclk;
	usb_power_suspend_control u_usb_power_suspend_control (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.bus_activity(bus_activity), .notify_pending(notify_pending),
		.usb_clk_en(usb_clk_en), .xcvr_low_power(xcvr_low_power), .pins_owned(pins_owned),
		.analog_en(analog_en), .outputs_hold(outputs_hold), .sleep_block(sleep_block),
		.irq(irq)
	);
	usb_far_end u_usb_far_end (.bus_activity(bus_activity), .notify_pending(notify_pending));
	task automatic test_done;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// bounded wait for hready high at a rising edge
	task automatic wait_rdy;
		int k;
		k = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1 && k < 50) begin
			@(posedge hclk);
			k++;
		end
		if (k >= 50) begin
			failures++;
			test_done;
		end
	endtask
	// one single word transfer; read data taken at the data-phase edge
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= usb_pwr_pkg::HTRANS_NONSEQ;
		haddr <= {24'h0, a};
		hwrite <= w;
		wait_rdy;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy;
		q = hrdata;
		chk("hresp", {31'h0, hresp}, 32'h0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		bus(a, 1'b0, 32'h0);
		chk("read", q, exp);
	endtask
	// reset values of all registers and the five module-side outputs
	task automatic t_reset;
		rd(usb_pwr_pkg::CTRL_OFS, 32'h0);
		rd(usb_pwr_pkg::STAT_OFS, 32'h0);
		rd(usb_pwr_pkg::MASK_OFS, 32'h0);
		chk("outs", {27'h0, outs}, 32'h9);
	endtask
	// all-ones write, then activity while suspended
	task automatic t_suspend;
		bus(usb_pwr_pkg::CTRL_OFS, 1'b1, 32'hFFFF_FFFF);
		repeat (2) @(posedge hclk);
		chk("outs", {27'h0, outs}, 32'hE);
		rd(usb_pwr_pkg::CTRL_OFS, 32'h1B);
		u_usb_far_end.burst(11);
		repeat (8) @(posedge hclk);
		rd(usb_pwr_pkg::CTRL_OFS, 32'h9B);
		chk("sleep", {31'h0, sleep_block}, 32'h1);
		bus(usb_pwr_pkg::CTRL_OFS, 1'b1, 32'h11);
		rd(usb_pwr_pkg::CTRL_OFS, 32'h19);
		rd(usb_pwr_pkg::STAT_OFS, 32'h1);
		chk("outs", {27'h0, outs}, 32'h16);
	endtask
	// guard set then cleared with a notification pending
	task automatic t_guard;
		chk("sleep", {31'h0, sleep_block}, 32'h0);
		u_usb_far_end.notify(1'b1);
		repeat (3) @(posedge hclk);
		chk("sleep", {31'h0, sleep_block}, 32'h1);
		bus(usb_pwr_pkg::CTRL_OFS, 1'b1, 32'h01);
		repeat (2) @(posedge hclk);
		chk("sleep", {31'h0, sleep_block}, 32'h0);
		u_usb_far_end.notify(1'b0);
	endtask
	// mask, clear, and a slow burst with the clock running
	task automatic t_irq;
		bus(usb_pwr_pkg::MASK_OFS, 1'b1, 32'h3);
		repeat (2) @(posedge hclk);
		chk("irq", {31'h0, irq}, 32'h1);
		bus(usb_pwr_pkg::STAT_OFS, 1'b1, 32'h1);
		repeat (2) @(posedge hclk);
		chk("irq", {31'h0, irq}, 32'h0);
		u_usb_far_end.burst(40);
		repeat (12) @(posedge hclk);
		rd(usb_pwr_pkg::CTRL_OFS, 32'h09);
		chk("irq", {31'h0, irq}, 32'h1);
		bus(usb_pwr_pkg::STAT_OFS, 1'b1, 32'h1);
	endtask
	// power off: busy holds for the settle time, then ready event
	task automatic t_off;
		bus(usb_pwr_pkg::CTRL_OFS, 1'b1, 32'h0);
		repeat (2) @(posedge hclk);
		chk("outs", {27'h0, outs}, 32'h9);
		rd(usb_pwr_pkg::CTRL_OFS, 32'h08);
		n = 0;
		q = 32'h8;
		// only the control register is touched while off and busy
		while (q[3] !== 1'b0 && n < 200) begin
			bus(usb_pwr_pkg::CTRL_OFS, 1'b0, 32'h0);
			n++;
		end
		chk("ctrl", q, 32'h0);
		// last poll samples 4n+6 cycles after power fell, the one before it 4n+2
		chk("polls", {31'h0, n * 4 + 6 >= usb_pwr_pkg::SETTLE_CYC}, 32'h1);
		chk("polls late", {31'h0, n * 4 + 2 <= usb_pwr_pkg::SETTLE_CYC + 1}, 32'h1);
		rd(usb_pwr_pkg::STAT_OFS, 32'h2);
		chk("irq", {31'h0, irq}, 32'h1);
		bus(8'h0C, 1'b1, 32'hFFFF_FFFF);
		rd(8'h0C, 32'h0);
	endtask
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset;
		t_suspend;
		t_guard;
		t_irq;
		t_off;
		test_done;
	end
endmodule // test_usb_power_suspend_control

// [testbench/usb_far_end.sv]
`timescale 1ns/1ps
// cable partner: drives the activity pin and the notification level
module usb_far_end (
	output logic bus_activity,
	output logic notify_pending
);
	// idle: no activity, nothing pending
	initial begin
		bus_activity = 1'b0;
		notify_pending = 1'b0;
	end
	// activity burst, deliberately off the bench clock grid
	task automatic burst(input int len_ns);
		#3 bus_activity = 1'b1;
		#(len_ns) bus_activity = 1'b0;
	endtask
	// notification level, called just after a rising edge
	task automatic notify(input logic v);
		notify_pending <= v;
	endtask
endmodule // usb_far_end

// [verilog/ahb_reg_slave.sv]
`timescale 1ns/1ps
// ahb-lite slave: one wait state per transfer so read data come from a flop
module ahb_reg_slave (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	reg_bus_if.bus_side rb
);
	logic busy_r;
	logic write_r;
	logic [usb_pwr_pkg::ADDR_W-1:0] addr_r;
	logic take;

	// only nonseq/seq transfers are taken; idle and busy are ignored
	assign take = hsel && htrans[1] && hready;
	assign rb.wr = busy_r && write_r;
	assign rb.rd = busy_r && !write_r;
	assign rb.addr = addr_r;
	assign rb.wdata = hwdata;

	// address phase capture and the single wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy_r <= 1'b0;
			write_r <= 1'b0;
			addr_r <= '0;
			hreadyout <= 1'b1;
		end else if (take) begin
			busy_r <= 1'b1;
			write_r <= hwrite;
			addr_r <= haddr[usb_pwr_pkg::ADDR_W-1:0];
			hreadyout <= 1'b0;
		end else begin
			busy_r <= 1'b0;
			hreadyout <= 1'b1;
		end
	end

	// read data held until the next read completes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= '0;
			hresp <= 1'b0;
		end else if (rb.rd) begin
			hrdata <= rb.rdata;
		end
	end
endmodule // ahb_reg_slave

// [verilog/reg_bus_if.sv]
`timescale 1ns/1ps
// register access strobes from the bus slave to the register file
interface reg_bus_if;
	logic wr;
	logic rd;
	logic [usb_pwr_pkg::ADDR_W-1:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	modport bus_side (output wr, output rd, output addr, output wdata, input rdata);
	modport reg_side (input wr, input rd, input addr, input wdata, output rdata);
endinterface

// [verilog/sync2.sv]
`timescale 1ns/1ps
// two-stage synchroniser for a pin level
module sync2 (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic d,
	output logic q
);
	logic meta_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= 1'b0;
			q <= 1'b0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule // sync2

// [verilog/usb_power_suspend_control.sv]
`timescale 1ns/1ps
// power, suspend and sleep-guard control for the usb module
module usb_power_suspend_control (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic bus_activity,
	input wire logic notify_pending,
	output logic usb_clk_en,
	output logic xcvr_low_power,
	output logic pins_owned,
	output logic analog_en,
	output logic outputs_hold,
	output logic sleep_block,
	output logic irq
);
	reg_bus_if rb ();

	logic pwr_r;
	logic susp_r;
	logic guard_r;
	logic busy_r;
	logic act_pend_r;
	logic act_prev_r;
	logic [usb_pwr_pkg::CNT_W-1:0] settle_r;
	logic [usb_pwr_pkg::EVT_W-1:0] stat_r;
	logic [usb_pwr_pkg::EVT_W-1:0] mask_r;
	logic [usb_pwr_pkg::EVT_W-1:0] evt;
	logic act_sync;
	logic act_edge;
	logic act_gen;
	logic ctrl_wr;
	logic stat_wr;
	logic mask_wr;
	logic busy_nxt;
	logic [31:0] ctrl_rd;

	// hsize is accepted but only whole-word transfers are meaningful
	ahb_reg_slave u_bus (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hwdata(hwdata),
		.hready(hready),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.rb(rb)
	);

	// activity comes straight off the cable, so it is synchronised first
	sync2 u_act (
		.clk(hclk),
		.rst_n(hresetn),
		.d(bus_activity),
		.q(act_sync)
	);

	// address match, shared by the three write strobes
	function automatic logic addr_hit(input logic [usb_pwr_pkg::ADDR_W-1:0] a,
			input logic [usb_pwr_pkg::ADDR_W-1:0] ofs);
		return a == ofs;
	endfunction

	// register write decode
	assign ctrl_wr = rb.wr && addr_hit(rb.addr, usb_pwr_pkg::CTRL_OFS);
	assign stat_wr = rb.wr && addr_hit(rb.addr, usb_pwr_pkg::STAT_OFS);
	assign mask_wr = rb.wr && addr_hit(rb.addr, usb_pwr_pkg::MASK_OFS);

	// control read image; unused bits are hard zero
	always_comb begin
		ctrl_rd = '0;
		ctrl_rd[usb_pwr_pkg::PWR_BIT] = pwr_r;
		ctrl_rd[usb_pwr_pkg::SUSP_BIT] = susp_r;
		ctrl_rd[usb_pwr_pkg::BUSY_BIT] = busy_r;
		ctrl_rd[usb_pwr_pkg::GUARD_BIT] = guard_r;
		ctrl_rd[usb_pwr_pkg::PEND_BIT] = act_pend_r;
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		unique case (rb.addr)
			usb_pwr_pkg::CTRL_OFS: rb.rdata = ctrl_rd;
			usb_pwr_pkg::STAT_OFS: rb.rdata = {30'h0000_0000, stat_r};
			usb_pwr_pkg::MASK_OFS: rb.rdata = {30'h0000_0000, mask_r};
			default: rb.rdata = '0;
		endcase
	end

	// writable control bits only; busy and pending are not writable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pwr_r <= usb_pwr_pkg::CTRL_RST[usb_pwr_pkg::PWR_BIT];
			susp_r <= usb_pwr_pkg::CTRL_RST[usb_pwr_pkg::SUSP_BIT];
			guard_r <= usb_pwr_pkg::CTRL_RST[usb_pwr_pkg::GUARD_BIT];
		end else if (ctrl_wr) begin
			pwr_r <= rb.wdata[usb_pwr_pkg::PWR_BIT];
			susp_r <= rb.wdata[usb_pwr_pkg::SUSP_BIT];
			guard_r <= rb.wdata[usb_pwr_pkg::GUARD_BIT];
		end
	end

	// settle counter: analog shut-down time before re-enable is safe
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			settle_r <= '0;
		end else if (pwr_r) begin
			settle_r <= usb_pwr_pkg::CNT_W'(usb_pwr_pkg::SETTLE_CYC);
		end else if (settle_r != '0) begin
			settle_r <= settle_r - 1'b1;
		end
	end

	// busy while on, and while the settle count runs after power-down
	assign busy_nxt = pwr_r || (settle_r != '0);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy_r <= 1'b0;
		end else begin
			busy_r <= busy_nxt;
		end
	end

	// activity edge; the interrupt can only be generated on a running clock
	assign act_edge = act_sync && !act_prev_r;
	assign act_gen = (act_edge || act_pend_r) && pwr_r && !susp_r;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			act_prev_r <= 1'b0;
		end else begin
			act_prev_r <= act_sync;
		end
	end

	// pending while activity waits for the gated clock to come back
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			act_pend_r <= 1'b0;
		end else if (!pwr_r || act_gen) begin
			act_pend_r <= 1'b0;
		end else if (act_edge && susp_r) begin
			act_pend_r <= 1'b1;
		end
	end

	// module-side outputs, all registered
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			usb_clk_en <= 1'b0;
			xcvr_low_power <= 1'b1;
			pins_owned <= 1'b0;
			analog_en <= 1'b0;
			outputs_hold <= 1'b1;
		end else begin
			usb_clk_en <= pwr_r && !susp_r;
			xcvr_low_power <= !pwr_r || susp_r;
			pins_owned <= pwr_r;
			analog_en <= pwr_r;
			outputs_hold <= !pwr_r;
		end
	end

	// sleep guard: level, follows activity and notifications
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sleep_block <= 1'b0;
		end else begin
			sleep_block <= guard_r && (act_sync || notify_pending || act_pend_r);
		end
	end

	// sticky events; a set in the clearing cycle wins
	assign evt[usb_pwr_pkg::EVT_ACT] = act_gen;
	assign evt[usb_pwr_pkg::EVT_READY] = busy_r && !busy_nxt;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stat_r <= usb_pwr_pkg::EVT_RST;
		end else begin
			stat_r <= (stat_r & ~(stat_wr ? rb.wdata[1:0] : 2'h0)) | evt;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mask_r <= usb_pwr_pkg::EVT_RST;
		end else if (mask_wr) begin
			mask_r <= rb.wdata[1:0];
		end
	end

	// level interrupt, one cycle behind the status bits
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(stat_r & mask_r);
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	pend_sets_a: assert property (
		act_edge && susp_r && pwr_r |=> act_pend_r && stat_r[0] == $past(stat_r[0]))
		else $error("activity in suspend did not set pending");
	pend_clears_a: assert property (
		act_pend_r && pwr_r && !susp_r |=> !act_pend_r ##0 stat_r[0])
		else $error("pending not turned into an interrupt");
	sleep_guard_a: assert property (
		(guard_r && notify_pending) |=> sleep_block)
		else $error("sleep not blocked on notification");
	guard_off_a: assert property (
		!guard_r |=> !sleep_block)
		else $error("sleep blocked with guard clear");
	busy_settle_a: assert property (
		$fell(pwr_r) |-> busy_r ##1 busy_r ##1 busy_r)
		else $error("busy dropped before settle time");
	busy_idle_a: assert property (
		!pwr_r && settle_r == '0 && !busy_r |=> !busy_r)
		else $error("busy set while off and settled");
	suspend_gate_a: assert property (
		susp_r && pwr_r |=> !usb_clk_en && xcvr_low_power)
		else $error("usb clock running in suspend");
	power_off_a: assert property (
		!pwr_r |=> outputs_hold && !pins_owned && !analog_en)
		else $error("outputs active while disabled");
	zero_bits_a: assert property (
		rb.rd && rb.addr == usb_pwr_pkg::CTRL_OFS
		|=> (hrdata & usb_pwr_pkg::CTRL_ZMASK) == 32'h0000_0000)
		else $error("unimplemented control bits read nonzero");
	ro_pend_a: assert property (
		ctrl_wr && rb.wdata[7] && !act_pend_r && !act_edge |=> !act_pend_r)
		else $error("write set the read-only pending bit");

	// the opposite direction of each rule but zero_bits_a, so that an output stuck at its
	// active level is caught as well as one that never gets there
	busy_on_a: assert property (
		pwr_r |=> busy_r)
		else $error("busy low while the module is on");
	busy_free_a: assert property (
		!pwr_r && settle_r == '0 |=> !busy_r)
		else $error("busy high after the settle time");
	settle_load_a: assert property (
		pwr_r |=> settle_r == usb_pwr_pkg::CNT_W'(usb_pwr_pkg::SETTLE_CYC))
		else $error("settle count not reloaded while on");
	settle_step_a: assert property (
		!pwr_r && settle_r != '0 |=> settle_r == $past(settle_r) - 1'b1)
		else $error("settle count did not step down");
	ready_evt_a: assert property (
		busy_r && !busy_nxt |=> stat_r[usb_pwr_pkg::EVT_READY])
		else $error("ready event lost when busy fell");
	clk_run_a: assert property (
		pwr_r && !susp_r |=> usb_clk_en && !xcvr_low_power)
		else $error("usb clock stopped outside suspend");
	power_on_a: assert property (
		pwr_r |=> !outputs_hold && pins_owned && analog_en)
		else $error("outputs still held while enabled");
	off_idle_a: assert property (
		!pwr_r |=> !usb_clk_en && xcvr_low_power)
		else $error("usb clock running while disabled");
	pend_off_a: assert property (
		!pwr_r |=> !act_pend_r)
		else $error("pending kept while disabled");
	pend_run_a: assert property (
		!susp_r |=> !act_pend_r)
		else $error("pending set with the clock running");
	act_evt_a: assert property (
		act_edge && pwr_r && !susp_r |=> stat_r[usb_pwr_pkg::EVT_ACT] && !act_pend_r)
		else $error("activity with clock running not reported");
	evt_wins_a: assert property (
		act_gen && stat_wr && rb.wdata[usb_pwr_pkg::EVT_ACT] |=> stat_r[usb_pwr_pkg::EVT_ACT])
		else $error("status clear beat a new activity event");
	sleep_act_a: assert property (
		guard_r && (act_sync || act_pend_r) |=> sleep_block)
		else $error("sleep not blocked on bus activity");
	sleep_free_a: assert property (
		guard_r && !act_sync && !notify_pending && !act_pend_r |=> !sleep_block)
		else $error("sleep blocked with nothing pending");
	pend_keep_a: assert property (
		ctrl_wr && act_pend_r && pwr_r && susp_r |=> act_pend_r)
		else $error("write cleared the read-only pending bit");

	// covers: the main scenarios, to see at a glance what a run reached
	guard_c: cover property (guard_r && notify_pending ##1 sleep_block);
	susp_c: cover property (ctrl_wr ##1 susp_r && pwr_r);
	pend_c: cover property (act_pend_r ##[1:50] !act_pend_r);
	ready_c: cover property ($fell(busy_r));
	irq_c: cover property ($rose(irq));
endmodule // usb_power_suspend_control

// [verilog/usb_pwr_pkg.sv]
// Function
// - bit 7 flags bus activity seen whose interrupt is not yet generated.
// - sleep guard set blocks sleep on activity or pending notification.
// - busy bit 3 reads 1 while active or disabled but not yet ready.
// - suspend bit 1 gates the 48 MHz clock and idles the transceiver.
// - power bit 0 turns module on; clearing it holds outputs, frees pins.
// - bits 31-8, 6-5 and 2 of the control register read zero.
package usb_pwr_pkg;
	localparam int ADDR_W = 8;
	// byte addresses of the registers
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [7:0] MASK_OFS = 8'h08;
	// control register fields
	localparam int PWR_BIT = 0;
	localparam int SUSP_BIT = 1;
	localparam int BUSY_BIT = 3;
	localparam int GUARD_BIT = 4;
	localparam int PEND_BIT = 7;
	localparam logic [31:0] CTRL_WMASK = 32'h0000_0013;
	localparam logic [31:0] CTRL_ZMASK = 32'hFFFF_FF64;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	// status and mask fields
	localparam int EVT_W = 2;
	localparam int EVT_ACT = 0;
	localparam int EVT_READY = 1;
	localparam logic [1:0] EVT_RST = 2'h0;
	// settle time after power-down before re-enable is allowed
	localparam int CLK_MHZ = 200;
	localparam int SETTLE_NS = 500;
	localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W = 8;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage
